// [lmu_pkg.sv]
// Purpose: shared constants and types for the lin mode uart engine
// Assumes: byte-wide register port with a 3-bit address
// Notes:   every offset, status and control bit position, baud and break reset value and threshold lives here
package lmu_pkg;

  // register addresses
  localparam logic [2:0] ADR_DATA    = 3'h0;  // write: transmit data, read: receive data
  localparam logic [2:0] ADR_STAT0   = 3'h1;
  localparam logic [2:0] ADR_CTRL0   = 3'h2;
  localparam logic [2:0] ADR_CTRL1_VIEW_SEL    = 3'h3;  // mode select for the shared control-1 address
  localparam logic [2:0] ADR_CTRL1   = 3'h4;
  localparam logic [2:0] ADR_BRKLEN  = 3'h5;  // [7:4] tx break length, [3:0] rx break length
  localparam logic [2:0] ADR_BAUD_HI = 3'h6;
  localparam logic [2:0] ADR_BAUD_LO = 3'h7;

  // view code that maps control-1 onto the lin control register
  localparam logic [2:0] VIEW_LIN = 3'h2;

  // status-0 bit positions
  localparam int STAT_RDA = 0;
  localparam int STAT_TDE = 1;
  localparam int STAT_TAE = 2;
  localparam int STAT_BRK = 3;
  localparam int STAT_OVR = 4;
  localparam int STAT_PLE = 5;
  localparam int STAT_FRM = 6;

  // control-0 bit positions
  localparam int C0_TXEN  = 7;
  localparam int C0_RXEN  = 6;
  localparam int C0_STOP2 = 2;
  localparam int C0_SEND_BREAK  = 0;

  // lin control bit positions
  localparam int C1_MST   = 7;
  localparam int C1_SLV   = 6;
  localparam int C1_AUTOBAUD_EN  = 5;
  localparam int C1_ST_LO = 0;

  // values after reset
  localparam logic [15:0] BAUD_RST   = 16'h0100;
  localparam logic [3:0]  TXBRK_RST  = 4'hD;     // thirteen bit times

  // break and wake-up thresholds in bit times
  localparam logic [4:0] BRK_WAIT_MIN = 5'h0B;
  localparam logic [4:0] BRK_ACT_MIN  = 5'h0A;
  localparam logic [4:0] WAKE_MIN     = 5'h03;
  localparam logic [4:0] LEN_SAT      = 5'h0F;
  localparam logic [4:0] LOW_SAT      = 5'h1F;

  // autobaud: falling edges after the first one, and prescaler top
  localparam logic [2:0]  AB_LAST_EDGE = 3'h3;
  localparam logic [2:0]  AB_PRE_MAX   = 3'h7;
  localparam logic [15:0] AB_CNT_MAX   = 16'hFFFF;

  typedef enum logic [1:0] {
    LMU_SLEEP    = 2'b00,
    LMU_WAIT_BRK = 2'b01,
    LMU_AUTOBAUD = 2'b10,
    LMU_ACTIVE   = 2'b11
  } lmu_lin_state_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_BREAK = 3'b001,
    TX_DELIM = 3'b010,
    TX_START = 3'b011,
    TX_DATA  = 3'b100,
    TX_STOP  = 3'b101
  } lmu_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } lmu_rx_state_t;

endpackage : lmu_pkg

// [lmu_bit_timer.sv]
// Purpose: free bit-interval timer giving mid-bit and end-of-bit pulses
// Assumes: period_i is the full bit interval in system clocks, at least 2
// Notes:   holds at zero while restart_i is high
`timescale 1ns/10ps
`default_nettype none
module lmu_bit_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             restart_i,
  input  wire logic [CNT_W-1:0] period_i,
  output logic                  mid_o,
  output logic                  end_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } lmu_tmr_t;

  lmu_tmr_t st_r;
  lmu_tmr_t st_nxt;

  // pulses decode the count only, so restart never loops back into them
  always_comb begin
    st_nxt = st_r;
    end_o  = (st_r.cnt == CNT_W'(period_i - CNT_W'(1)));
    mid_o  = (st_r.cnt == (period_i >> 1));
    if (restart_i || end_o) begin
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = CNT_W'(st_r.cnt + CNT_W'(1));
    end
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : lmu_bit_timer
`default_nettype wire

// [lmu_lin_engine.sv]
// Purpose: lin protocol mode of a uart: break, wake-up, autobaud, slave states
// Assumes: rxd_i comes from the transceiver, unsynchronised
// Notes:   baud reload holds the full bit interval in system clocks
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module lmu_lin_engine (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       rxd_i,
  output logic            txd_o
);

  typedef struct packed {
    logic                   rx_meta;
    logic                   rx_s;
    logic                   rx_d;
    logic                   tx_enable;
    logic                   rx_enable;
    logic                   stop2;
    logic                   send_break;
    logic [2:0]             ctrl1_view_sel;
    logic                   master_sel;
    logic                   slave_sel;
    logic                   autobaud_en;
    lmu_pkg::lmu_lin_state_t lin_fsm_state;
    logic [3:0]             tx_break_len;
    logic [3:0]             rx_break_len;
    logic [15:0]            baud;
    logic [7:0]             tx_hold;
    logic                   hold_full;
    logic                   tx_data_empty;
    lmu_pkg::lmu_tx_state_t tx_st;
    logic [7:0]             tx_sh;
    logic [3:0]             tx_bits;
    logic                   txd;
    lmu_pkg::lmu_rx_state_t rx_st;
    logic [7:0]             rx_sh;
    logic [2:0]             rx_bits;
    logic [7:0]             rx_data;
    logic                   rx_data_avail;
    logic                   break_detect_flag;
    logic                   ovr_flag;
    logic                   parity_err_flag;
    logic                   frm_flag;
    logic [4:0]             low_bits;
    logic                   ab_run;
    logic                   ab_halt;
    logic [2:0]             ab_edges;
    logic [2:0]             ab_pre;
    logic [15:0]            ab_cnt;
    logic [7:0]             rdata;
  } lmu_state_t;

  lmu_state_t st_r;
  lmu_state_t st_nxt;

  logic       tx_restart;
  logic       tx_mid;
  logic       tx_end;
  logic       rx_restart;
  logic       rx_mid;
  logic       low_restart;
  logic       low_end;
  logic       fall;
  logic       rise;
  logic       rx_on;
  logic       tx_all_empty;
  logic       lin_wr;
  logic [7:0] stat0;
  logic [3:0] brk_len;

  // transmit bit clock, parked while idle so a character starts on a full bit
  lmu_bit_timer #(.CNT_W(16)) u_tx_tmr (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (tx_restart),
    .period_i  (st_r.baud),
    .mid_o     (tx_mid),
    .end_o     (tx_end)
  );

  // receive sampling clock, aligned to the start-bit falling edge
  lmu_bit_timer #(.CNT_W(16)) u_rx_tmr (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (rx_restart),
    .period_i  (st_r.baud),
    .mid_o     (rx_mid),
    .end_o     ()
  );

  // low-period timer: counts bit times while the line is held low
  lmu_bit_timer #(.CNT_W(16)) u_low_tmr (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (low_restart),
    .period_i  (st_r.baud),
    .mid_o     (),
    .end_o     (low_end)
  );

  // line edges use only the second and third sync stages
  assign fall         = st_r.rx_d & ~st_r.rx_s;
  assign rise         = ~st_r.rx_d & st_r.rx_s;
  assign tx_restart   = (st_r.tx_st == lmu_pkg::TX_IDLE);
  assign rx_restart   = (st_r.rx_st == lmu_pkg::RX_IDLE);
  assign low_restart  = st_r.rx_s;
  assign rx_on        = st_r.rx_enable && (st_r.lin_fsm_state == lmu_pkg::LMU_ACTIVE);
  assign tx_all_empty = (st_r.tx_st == lmu_pkg::TX_IDLE) && !st_r.hold_full;
  assign lin_wr       = reg_wr_i && (reg_addr_i == lmu_pkg::ADR_CTRL1)
                        && (st_r.ctrl1_view_sel == lmu_pkg::VIEW_LIN);
  assign brk_len      = (st_r.low_bits > lmu_pkg::LEN_SAT) ? 4'hF : st_r.low_bits[3:0];
  assign txd_o        = st_r.txd;
  assign reg_rdata_o  = st_r.rdata;

  // status-0 view
  always_comb begin
    stat0                    = 8'h00;
    stat0[lmu_pkg::STAT_RDA] = st_r.rx_data_avail;
    stat0[lmu_pkg::STAT_TDE] = st_r.tx_data_empty;
    stat0[lmu_pkg::STAT_TAE] = tx_all_empty;
    stat0[lmu_pkg::STAT_BRK] = st_r.break_detect_flag;
    stat0[lmu_pkg::STAT_OVR] = st_r.ovr_flag;
    stat0[lmu_pkg::STAT_PLE] = st_r.parity_err_flag;
    stat0[lmu_pkg::STAT_FRM] = st_r.frm_flag;
  end

  // next state: software clears first, then hardware events, then software writes,
  // so a flag set by hardware survives a clear in the same cycle
  always_comb begin
    st_nxt         = st_r;
    st_nxt.rx_meta = rxd_i;
    st_nxt.rx_s    = st_r.rx_meta;
    st_nxt.rx_d    = st_r.rx_s;
    st_nxt.rdata   = 8'h00;

    // software clears
    if (reg_wr_i && reg_addr_i == lmu_pkg::ADR_STAT0) begin
      if (reg_wdata_i[lmu_pkg::STAT_BRK]) st_nxt.break_detect_flag = 1'b0;
      if (reg_wdata_i[lmu_pkg::STAT_OVR]) st_nxt.ovr_flag = 1'b0;
      if (reg_wdata_i[lmu_pkg::STAT_PLE]) st_nxt.parity_err_flag = 1'b0;
      if (reg_wdata_i[lmu_pkg::STAT_FRM]) st_nxt.frm_flag = 1'b0;
    end
    if (reg_rd_i && reg_addr_i == lmu_pkg::ADR_DATA) begin
      st_nxt.rx_data_avail = 1'b0;
    end
    if (reg_wr_i && reg_addr_i == lmu_pkg::ADR_DATA) begin
      st_nxt.tx_data_empty = 1'b0;
    end

    // transmitter
    case (st_r.tx_st)
      lmu_pkg::TX_IDLE: begin
        if (st_r.tx_enable && st_r.send_break) begin
          st_nxt.tx_st   = lmu_pkg::TX_BREAK;
          st_nxt.tx_bits = 4'h0;
        end else if (st_r.tx_enable && st_r.hold_full) begin
          st_nxt.tx_st     = lmu_pkg::TX_START;
          st_nxt.tx_sh     = st_r.tx_hold;
          st_nxt.hold_full = 1'b0;
        end
      end
      lmu_pkg::TX_START: begin
        if (tx_end) begin
          st_nxt.tx_data_empty = 1'b1;
          st_nxt.tx_st         = lmu_pkg::TX_DATA;
          st_nxt.tx_bits       = 4'h0;
        end
      end
      lmu_pkg::TX_DATA: begin
        if (tx_end) begin
          st_nxt.tx_sh   = {1'b0, st_r.tx_sh[7:1]};
          st_nxt.tx_bits = 4'(st_r.tx_bits + 4'h1);
          if (st_r.tx_bits == 4'h7) begin
            st_nxt.tx_st   = lmu_pkg::TX_STOP;
            st_nxt.tx_bits = 4'h0;
          end
        end
      end
      lmu_pkg::TX_STOP: begin
        if (tx_end) begin
          if (st_r.stop2 && st_r.tx_bits == 4'h0) begin
            st_nxt.tx_bits = 4'h1;
          end else if (st_r.send_break) begin
            st_nxt.tx_st   = lmu_pkg::TX_BREAK;
            st_nxt.tx_bits = 4'h0;
          end else if (st_r.hold_full) begin
            st_nxt.tx_st     = lmu_pkg::TX_START;
            st_nxt.tx_sh     = st_r.tx_hold;
            st_nxt.hold_full = 1'b0;
          end else begin
            st_nxt.tx_st = lmu_pkg::TX_IDLE;
          end
        end
      end
      lmu_pkg::TX_BREAK: begin
        if (tx_end) begin
          st_nxt.tx_bits = 4'(st_r.tx_bits + 4'h1);
          if (4'(st_r.tx_bits + 4'h1) >= st_r.tx_break_len) begin
            st_nxt.send_break = 1'b0;
            st_nxt.tx_st      = lmu_pkg::TX_DELIM;
          end
        end
      end
      lmu_pkg::TX_DELIM: begin
        if (tx_end) begin
          st_nxt.tx_st = lmu_pkg::TX_IDLE;
        end
      end
      default: st_nxt.tx_st = lmu_pkg::TX_IDLE;
    endcase

    // line level follows the next state so the pin is a clean flop output
    case (st_nxt.tx_st)
      lmu_pkg::TX_START: st_nxt.txd = 1'b0;
      lmu_pkg::TX_BREAK: st_nxt.txd = 1'b0;
      lmu_pkg::TX_DATA:  st_nxt.txd = st_nxt.tx_sh[0];
      default:           st_nxt.txd = 1'b1;
    endcase

    // loopback compare at bit centre; tolerates transceiver delay up to half a bit
    if (tx_mid && (st_r.tx_st == lmu_pkg::TX_START || st_r.tx_st == lmu_pkg::TX_DATA
                   || st_r.tx_st == lmu_pkg::TX_STOP) && (st_r.rx_s != st_r.txd)) begin
      st_nxt.parity_err_flag = 1'b1;
    end

    // receiver: a dropped enable or state change abandons any character
    if (!rx_on) begin
      st_nxt.rx_st = lmu_pkg::RX_IDLE;
    end else begin
      case (st_r.rx_st)
        lmu_pkg::RX_IDLE: begin
          if (fall) st_nxt.rx_st = lmu_pkg::RX_START;
        end
        lmu_pkg::RX_START: begin
          if (rx_mid) begin
            st_nxt.rx_st   = st_r.rx_s ? lmu_pkg::RX_IDLE : lmu_pkg::RX_DATA;
            st_nxt.rx_bits = 3'h0;
          end
        end
        lmu_pkg::RX_DATA: begin
          if (rx_mid) begin
            st_nxt.rx_sh   = {st_r.rx_s, st_r.rx_sh[7:1]};
            st_nxt.rx_bits = 3'(st_r.rx_bits + 3'h1);
            if (st_r.rx_bits == 3'h7) st_nxt.rx_st = lmu_pkg::RX_STOP;
          end
        end
        lmu_pkg::RX_STOP: begin
          if (rx_mid) begin
            st_nxt.rx_st = lmu_pkg::RX_IDLE;
            if (st_r.rx_s && st_r.rx_data_avail) begin
              st_nxt.ovr_flag = 1'b1;
            end else if (st_r.rx_s) begin
              st_nxt.rx_data       = st_r.rx_sh;
              st_nxt.rx_data_avail = 1'b1;
            end else if (st_r.rx_sh != 8'h00) begin
              st_nxt.frm_flag = 1'b1; // all-zero low stop is a break, left to the break timer
            end
          end
        end
        default: st_nxt.rx_st = lmu_pkg::RX_IDLE;
      endcase
    end

    // low-period length in bit times, saturating
    if (fall) begin
      st_nxt.low_bits = 5'h00;
    end else if (!st_r.rx_s && low_end && st_r.low_bits != lmu_pkg::LOW_SAT) begin
      st_nxt.low_bits = 5'(st_r.low_bits + 5'h01);
    end

    // break and wake-up judged when the line returns high
    if (rise) begin
      if (st_r.lin_fsm_state == lmu_pkg::LMU_SLEEP && st_r.low_bits >= lmu_pkg::WAKE_MIN) begin
        st_nxt.break_detect_flag = 1'b1;
        st_nxt.rx_break_len      = brk_len;
      end else if (st_r.slave_sel && st_r.lin_fsm_state == lmu_pkg::LMU_WAIT_BRK
                   && st_r.low_bits >= lmu_pkg::BRK_WAIT_MIN) begin
        st_nxt.break_detect_flag = 1'b1;
        st_nxt.rx_break_len      = brk_len;
        st_nxt.lin_fsm_state     = lmu_pkg::LMU_AUTOBAUD;
        st_nxt.ab_run            = 1'b0;
        st_nxt.ab_halt           = 1'b0;
      end else if (st_r.slave_sel && st_r.lin_fsm_state == lmu_pkg::LMU_ACTIVE
                   && st_r.low_bits >= lmu_pkg::BRK_ACT_MIN) begin
        st_nxt.break_detect_flag = 1'b1;
        st_nxt.rx_break_len      = brk_len;
        st_nxt.lin_fsm_state     = lmu_pkg::LMU_AUTOBAUD;
        st_nxt.ab_run            = 1'b0;
        st_nxt.ab_halt           = 1'b0;
      end
    end

    // autobaud: start bit edge to bit 7 edge of the synch byte is eight bit times;
    // counting in eighths makes the final count the bit interval directly
    if (st_r.lin_fsm_state == lmu_pkg::LMU_AUTOBAUD && !st_r.ab_halt) begin
      if (fall && !st_r.ab_run) begin
        st_nxt.ab_run   = 1'b1;
        st_nxt.ab_edges = 3'h0;
        st_nxt.ab_pre   = 3'h1; // count the edge cycle
        st_nxt.ab_cnt   = 16'h0000;
      end else if (fall && st_r.ab_edges == lmu_pkg::AB_LAST_EDGE) begin
        st_nxt.ab_run        = 1'b0;
        st_nxt.lin_fsm_state = lmu_pkg::LMU_ACTIVE;
        if (st_r.autobaud_en) st_nxt.baud = st_r.ab_cnt;
      end else if (st_r.ab_run) begin
        if (fall) st_nxt.ab_edges = 3'(st_r.ab_edges + 3'h1);
        st_nxt.ab_pre = 3'(st_r.ab_pre + 3'h1);
        if (st_r.ab_pre == lmu_pkg::AB_PRE_MAX) begin
          if (st_r.ab_cnt == lmu_pkg::AB_CNT_MAX) begin
            st_nxt.ovr_flag = 1'b1;
            st_nxt.ab_run   = 1'b0;
            st_nxt.ab_halt  = 1'b1; // wait for software to restart the slave
          end else begin
            st_nxt.ab_cnt = 16'(st_r.ab_cnt + 16'h0001);
          end
        end
      end
    end

    // software writes; state field writes override hardware advances
    if (reg_wr_i) begin
      if (reg_addr_i == lmu_pkg::ADR_DATA) begin
        st_nxt.tx_hold   = reg_wdata_i;
        st_nxt.hold_full = 1'b1;
      end else if (reg_addr_i == lmu_pkg::ADR_CTRL0) begin
        st_nxt.tx_enable = reg_wdata_i[lmu_pkg::C0_TXEN];
        st_nxt.rx_enable = reg_wdata_i[lmu_pkg::C0_RXEN];
        st_nxt.stop2     = reg_wdata_i[lmu_pkg::C0_STOP2];
        if (reg_wdata_i[lmu_pkg::C0_SEND_BREAK]) st_nxt.send_break = 1'b1;
      end else if (reg_addr_i == lmu_pkg::ADR_CTRL1_VIEW_SEL) begin
        st_nxt.ctrl1_view_sel = reg_wdata_i[2:0];
      end else if (lin_wr) begin
        st_nxt.master_sel    = reg_wdata_i[lmu_pkg::C1_MST];
        st_nxt.slave_sel     = reg_wdata_i[lmu_pkg::C1_SLV];
        st_nxt.autobaud_en   = reg_wdata_i[lmu_pkg::C1_AUTOBAUD_EN];
        st_nxt.lin_fsm_state = lmu_pkg::lmu_lin_state_t'(reg_wdata_i[lmu_pkg::C1_ST_LO +: 2]);
        st_nxt.ab_run        = 1'b0;
        st_nxt.ab_halt       = 1'b0;
      end else if (reg_addr_i == lmu_pkg::ADR_BRKLEN) begin
        st_nxt.tx_break_len = reg_wdata_i[7:4];
      end else if (reg_addr_i == lmu_pkg::ADR_BAUD_HI) begin
        st_nxt.baud[15:8] = reg_wdata_i;
      end else if (reg_addr_i == lmu_pkg::ADR_BAUD_LO) begin
        st_nxt.baud[7:0] = reg_wdata_i;
      end
    end

    // read data, valid only in the cycle after the strobe
    if (reg_rd_i) begin
      if (reg_addr_i == lmu_pkg::ADR_DATA) begin
        st_nxt.rdata = st_r.rx_data;
      end else if (reg_addr_i == lmu_pkg::ADR_STAT0) begin
        st_nxt.rdata = stat0;
      end else if (reg_addr_i == lmu_pkg::ADR_CTRL0) begin
        st_nxt.rdata = {st_r.tx_enable, st_r.rx_enable, 3'h0, st_r.stop2, 1'b0, st_r.send_break};
      end else if (reg_addr_i == lmu_pkg::ADR_CTRL1_VIEW_SEL) begin
        st_nxt.rdata = {5'h00, st_r.ctrl1_view_sel};
      end else if (reg_addr_i == lmu_pkg::ADR_CTRL1) begin
        if (st_r.ctrl1_view_sel == lmu_pkg::VIEW_LIN) begin
          st_nxt.rdata = {st_r.master_sel, st_r.slave_sel, st_r.autobaud_en, 3'h0, st_r.lin_fsm_state};
        end
      end else if (reg_addr_i == lmu_pkg::ADR_BRKLEN) begin
        st_nxt.rdata = {st_r.tx_break_len, st_r.rx_break_len};
      end else if (reg_addr_i == lmu_pkg::ADR_BAUD_HI) begin
        st_nxt.rdata = st_r.baud[15:8];
      end else begin
        st_nxt.rdata = st_r.baud[7:0];
      end
    end
  end

  // state register; sync stages reset to the idle-high line level
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_r               <= '0;
      st_r.rx_meta       <= 1'b1;
      st_r.rx_s          <= 1'b1;
      st_r.rx_d          <= 1'b1;
      st_r.txd           <= 1'b1;
      st_r.tx_data_empty <= 1'b1;
      st_r.baud          <= lmu_pkg::BAUD_RST;
      st_r.tx_break_len  <= lmu_pkg::TXBRK_RST;
      st_r.lin_fsm_state <= lmu_pkg::LMU_SLEEP;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : lmu_lin_engine
`default_nettype wire

// [lmu_lin_engine_asserts.sv]
// Purpose: port-level checks of the lin mode uart engine
// Assumes: one clock, synchronous active-high reset
// Notes:   the software-only view select and tx break length fields are mirrored
`timescale 1ns/10ps
`default_nettype none
module lmu_lin_engine_asserts (
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       rxd_i,
  input wire logic       txd_o
);
  logic [2:0] view_r;
  logic [3:0] txbrk_r;
  wire rd_st = reg_rd_i && reg_addr_i == lmu_pkg::ADR_STAT0;
  wire rd_c1 = reg_rd_i && reg_addr_i == lmu_pkg::ADR_CTRL1;
  wire wr_c1 = reg_wr_i && reg_addr_i == lmu_pkg::ADR_CTRL1;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // mirror of fields only software writes, so readback has a reference
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      view_r  <= 3'h0;
      txbrk_r <= lmu_pkg::TXBRK_RST;
    end else if (reg_wr_i && reg_addr_i == lmu_pkg::ADR_CTRL1_VIEW_SEL) begin
      view_r <= reg_wdata_i[2:0];
    end else if (reg_wr_i && reg_addr_i == lmu_pkg::ADR_BRKLEN) begin
      txbrk_r <= reg_wdata_i[7:4];
    end
  end
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  ctrl1_hide_a: assert property (rd_c1 && view_r != lmu_pkg::VIEW_LIN |=> reg_rdata_o == 8'h00)
    else $error("control-1 visible outside lin view");
  view_rb_a: assert property (reg_rd_i && reg_addr_i == lmu_pkg::ADR_CTRL1_VIEW_SEL |=> reg_rdata_o[2:0] == view_r)
    else $error("view select readback wrong");
  txbrk_rb_a: assert property (reg_rd_i && reg_addr_i == lmu_pkg::ADR_BRKLEN |=> reg_rdata_o[7:4] == txbrk_r)
    else $error("tx break length readback wrong");
  tde_clr_a: assert property (reg_wr_i && reg_addr_i == lmu_pkg::ADR_DATA ##1 rd_st |=> !reg_rdata_o[1])
    else $error("data-empty not cleared by write");
  send_break_hold_a: assert property (reg_wr_i && reg_addr_i == lmu_pkg::ADR_CTRL0 && reg_wdata_i[0]
    ##1 reg_rd_i && reg_addr_i == lmu_pkg::ADR_CTRL0 |=> reg_rdata_o[0]) else $error("send-break lost");
  state_rb_a: assert property (wr_c1 && view_r == lmu_pkg::VIEW_LIN ##1 rd_c1
    |=> (reg_rdata_o & 8'hE3) == ($past(reg_wdata_i, 2) & 8'hE3)) else $error("lin control readback wrong");
  stat_hi_a: assert property (rd_st |=> !reg_rdata_o[7])
    else $error("unused status bit set");
  cover property (rd_st ##1 reg_rdata_o[lmu_pkg::STAT_PLE]);
  cover property (rd_st ##1 reg_rdata_o[lmu_pkg::STAT_BRK]);
  cover property ($fell(txd_o) ##1 !txd_o [*8]);
endmodule : lmu_lin_engine_asserts
bind lmu_lin_engine lmu_lin_engine_asserts u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .rxd_i(rxd_i), .txd_o(txd_o));
`default_nettype wire

// [lmu_bus_node.sv]
// Purpose: lin bus with transceiver and one remote node
// Assumes: bus is wired-and with a pull-up, so released means high
// Notes:   flip_i disturbs the echo only when a scenario asks for it
`timescale 1ns/10ps
`default_nettype none
module lmu_bus_node (
  input  wire logic sys_clk_i,
  input  wire logic txd_i,
  input  wire logic pull_low_i,
  input  wire logic flip_i,
  output logic      rxd_o
);
  logic [1:0] dly_r = 2'b11;
  // two-cycle loop delay through the transceiver, echo must still match
  always @(posedge sys_clk_i) dly_r <= {dly_r[0], (txd_i & ~pull_low_i) ^ flip_i};
  assign rxd_o = dly_r[1];
endmodule : lmu_bus_node
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench for the lin mode uart engine
// Assumes: master bit time 16 clocks, remote master 24 clocks per bit
// Notes:   reads checked a cycle late
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int BT = 16;
  localparam int ST = 24;
  typedef struct {logic [2:0] a; logic [7:0] e; logic [7:0] m;} lmu_note_t;
  logic       clk, rst, wr, rd, rd_d, txd, rxd, pull, flip;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, b, x;
  int         n_mismatch, checks_done, cyc, t0, ts, seed;
  lmu_note_t  notes[$];
  lmu_lin_engine uut (.sys_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rxd_i(rxd), .txd_o(txd));
  lmu_bus_node u_node (.sys_clk_i(clk), .txd_i(txd), .pull_low_i(pull), .flip_i(flip), .rxd_o(rxd));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask : chk
  // read data is due one cycle after the strobe, oldest note first
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_d <= rd & ~rst;
    if (rd_d) begin
      chk($sformatf("reg %0d", notes[0].a), {8'h00, notes[0].e & notes[0].m}, {8'h00, rdata & notes[0].m});
      void'(notes.pop_front());
    end
  end
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask : bus
  task automatic step();
    bus(1'b0, 1'b0, addr, wdata);
  endtask : step
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    notes.push_back('{a, e, m});
    bus(1'b0, 1'b1, a, wdata);
  endtask : rd_reg
  task automatic edge_to(input logic lvl);
    for (int k = 0; k < 4000 && txd !== lvl; k++) step();
  endtask : edge_to
  // samples at bit centres from the start edge; returns at the stop bit centre
  task automatic get_char(output logic [7:0] c);
    edge_to(1'b1);
    edge_to(1'b0);
    ts = cyc;
    repeat (BT + BT / 2) step();
    for (int i = 0; i < 8; i++) begin
      c[i] = txd;
      repeat (BT) step();
    end
  endtask : get_char
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      pull <= ~f[i];
      repeat (ST) step();
    end
  endtask : send
  task automatic low(input int n);
    pull <= 1'b1;
    repeat (n) step();
    pull <= 1'b0;
    repeat (2 * ST) step();
  endtask : low
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    {rst, wr, rd, rd_d, pull, flip, addr, wdata, cyc, n_mismatch, checks_done} = '0;
    rst = 1'b1;
    seed = 32'h654fe070;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(lmu_pkg::ADR_STAT0, 8'h06, 8'hFF);
    rd_reg(lmu_pkg::ADR_BRKLEN, 8'hD0, 8'hFF);
    rd_reg(lmu_pkg::ADR_CTRL1, 8'h00, 8'hFF);
    wr_reg(lmu_pkg::ADR_BAUD_HI, 8'h00);
    wr_reg(lmu_pkg::ADR_BAUD_LO, 8'(BT));
    wr_reg(lmu_pkg::ADR_CTRL1_VIEW_SEL, 8'h02);
    rd_reg(lmu_pkg::ADR_CTRL1_VIEW_SEL, 8'h02, 8'h07);
    wr_reg(lmu_pkg::ADR_CTRL0, 8'hC0);
    wr_reg(lmu_pkg::ADR_CTRL1, 8'h83);
    rd_reg(lmu_pkg::ADR_CTRL1, 8'h83, 8'hE3);
    wr_reg(lmu_pkg::ADR_CTRL0, 8'hC1);
    rd_reg(lmu_pkg::ADR_CTRL0, 8'h01, 8'h01);
    wr_reg(lmu_pkg::ADR_DATA, 8'h55);
    edge_to(1'b0);
    t0 = cyc;
    edge_to(1'b1);
    chk("break cycles", 16'(13 * BT), 16'(cyc - t0));
    t0 = cyc;
    get_char(b);
    chk("delimiter", 16'(BT + 1), 16'(ts - t0));
    chk("synch", 16'h0055, {8'h00, b});
    rd_reg(lmu_pkg::ADR_CTRL0, 8'h00, 8'h01);
    rd_reg(lmu_pkg::ADR_STAT0, 8'h00, 8'h20);
    wr_reg(lmu_pkg::ADR_DATA, 8'h3C);
    rd_reg(lmu_pkg::ADR_STAT0, 8'h00, 8'h02);
    get_char(b);
    t0 = ts;
    rd_reg(lmu_pkg::ADR_STAT0, 8'h02, 8'h02);
    wr_reg(lmu_pkg::ADR_DATA, 8'hA7);
    get_char(x);
    chk("char gap", 16'(10 * BT), 16'(ts - t0));
    chk("chars", 16'h3CA7, {b, x});
    wr_reg(lmu_pkg::ADR_DATA, 8'hF0);
    repeat (3 * BT) step();
    flip <= 1'b1;
    repeat (BT) step();
    flip <= 1'b0;
    repeat (10 * BT) step();
    rd_reg(lmu_pkg::ADR_STAT0, 8'h20, 8'h20);
    rd_reg(lmu_pkg::ADR_DATA, 8'h00, 8'h00);
    wr_reg(lmu_pkg::ADR_STAT0, 8'h78);
    wr_reg(lmu_pkg::ADR_CTRL1, 8'h61);
    low(8 * BT);
    rd_reg(lmu_pkg::ADR_STAT0, 8'h00, 8'h08);
    rd_reg(lmu_pkg::ADR_CTRL1, 8'h01, 8'h03);
    low(20 * BT);
    rd_reg(lmu_pkg::ADR_STAT0, 8'h08, 8'h08);
    rd_reg(lmu_pkg::ADR_BRKLEN, 8'h0F, 8'h0F);
    rd_reg(lmu_pkg::ADR_CTRL1, 8'h02, 8'h03);
    send(8'h55);
    repeat (ST) step();
    rd_reg(lmu_pkg::ADR_BAUD_LO, 8'(ST), 8'hFF);
    rd_reg(lmu_pkg::ADR_BAUD_HI, 8'h00, 8'hFF);
    rd_reg(lmu_pkg::ADR_CTRL1, 8'h03, 8'h03);
    x = 8'($random(seed));
    wr_reg(lmu_pkg::ADR_STAT0, 8'h78);
    send(x);
    send(8'h3C);
    repeat (ST) step();
    rd_reg(lmu_pkg::ADR_STAT0, 8'h11, 8'h11);
    rd_reg(lmu_pkg::ADR_DATA, x, 8'hFF);
    wr_reg(lmu_pkg::ADR_CTRL1, 8'h61);
    send(x);
    rd_reg(lmu_pkg::ADR_STAT0, 8'h00, 8'h01);
    wr_reg(lmu_pkg::ADR_CTRL1, 8'h63);
    wr_reg(lmu_pkg::ADR_STAT0, 8'h78);
    low(12 * ST + ST / 2);
    rd_reg(lmu_pkg::ADR_STAT0, 8'h08, 8'h08);
    rd_reg(lmu_pkg::ADR_CTRL1, 8'h02, 8'h03);
    wr_reg(lmu_pkg::ADR_CTRL1, 8'h00);
    rd_reg(lmu_pkg::ADR_CTRL1, 8'h00, 8'h03);
    wr_reg(lmu_pkg::ADR_STAT0, 8'h78);
    low(2 * ST);
    rd_reg(lmu_pkg::ADR_STAT0, 8'h00, 8'h08);
    low(4 * ST + ST / 2);
    rd_reg(lmu_pkg::ADR_STAT0, 8'h08, 8'h08);
    rd_reg(lmu_pkg::ADR_BRKLEN, 8'h04, 8'h0F);
    rd_reg(lmu_pkg::ADR_CTRL1, 8'h00, 8'h03);
    repeat (4) step();
    test_done();
  end
endmodule : testbench
`default_nettype wire
